// *** atram_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// register and stream bench
// ****
module audio_tx_reset_alias_and_mask_bench
    import atram_pkg::*;
;
    localparam int DEPTH = 4;
    localparam logic [7:0] ALS = OFS_TX_GLOBAL_CTRL_ALIAS;
    localparam logic [31:0] W0 = 32'h1234_5678;
    localparam logic [31:0] M0 = 32'hff00_ff00;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, tx_in_valid = 1'b0;
    logic stall = 1'b0, slow = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, tx_in_data = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, tx_in_ready;
    logic tx_out_valid, tx_out_ready;
    logic [1:0] bresp, rresp, sel;
    logic [31:0] rdata, tx_out_data, pad;
    logic [4:0] src;
    logic tx_fsync_gen_run, tx_state_machine_run, tx_serializer_active;
    logic tx_hf_divider_run, tx_bit_divider_run, rx_fsync_gen_run;
    logic rx_state_machine_run, rx_serializer_active, rx_hf_divider_run;
    logic rx_bit_divider_run;
    wire logic [9:0] runs = {tx_fsync_gen_run, tx_state_machine_run,
        tx_serializer_active, tx_hf_divider_run, tx_bit_divider_run,
        rx_fsync_gen_run, rx_state_machine_run, rx_serializer_active,
        rx_hf_divider_run, rx_bit_divider_run};
    int fail_count = 0;
    int checks = 0;
    int n;
    bit ok;
    always #5 aclk = ~aclk;
    atram_top #(.FIFO_DEPTH(DEPTH)) DUT (.aclk, .aresetn, .awvalid, .awaddr,
        .awprot, .awready, .wvalid, .wdata, .wstrb, .wready, .bvalid, .bresp,
        .bready, .arvalid, .araddr, .arprot, .arready, .rvalid, .rdata,
        .rresp, .rready, .tx_in_valid, .tx_in_data, .tx_in_ready,
        .tx_out_valid, .tx_out_data, .tx_out_ready, .tx_fsync_gen_run,
        .tx_state_machine_run, .tx_serializer_active, .tx_hf_divider_run,
        .tx_bit_divider_run, .rx_fsync_gen_run, .rx_state_machine_run,
        .rx_serializer_active, .rx_hf_divider_run, .rx_bit_divider_run);
    atram_sink u_sink (.aclk, .aresetn, .stall, .slow, .tx_out_valid,
        .tx_out_data, .tx_out_ready);
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic expire();
        fail_count++;
        finish_test();
    endtask
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // each beat held until its own ready, answers taken at the same edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic a_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int k = 0; !b_t; k++)
        begin
            if (k > 40) expire();
            @(negedge aclk);
            a_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            if (b_t) check("write resp", {30'h0, bresp}, {30'h0, er});
            @(posedge aclk);
            if (a_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) bready <= 1'b0;
        end
        @(negedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        logic a_t, r_t;
        r_t = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int k = 0; !r_t; k++)
        begin
            if (k > 40) expire();
            @(negedge aclk);
            a_t = arvalid && arready;
            r_t = rvalid;
            if (r_t) check("read data", rdata, e);
            if (r_t) check("read resp", {30'h0, rresp}, {30'h0, er});
            @(posedge aclk);
            if (a_t) arvalid <= 1'b0;
            if (r_t) rready <= 1'b0;
        end
        @(negedge aclk);
    endtask
    // a refused push gives up after a fixed patience, not a failure
    task automatic push(input logic [31:0] d, output bit t);
        t = 1'b0;
        @(posedge aclk);
        tx_in_valid <= 1'b1;
        tx_in_data <= d;
        for (int k = 0; k < 20 && !t; k++)
        begin
            @(negedge aclk);
            t = tx_in_ready === 1'b1;
            @(posedge aclk);
        end
        tx_in_valid <= 1'b0;
        @(negedge aclk);
    endtask
    task automatic wait_out(input int want);
        for (int k = 0; u_sink.seen.size() < want; k++)
        begin
            if (k > 60) expire();
            @(negedge aclk);
        end
    endtask
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ALS, 32'h0000_0000, RESP_OKAY);
        rd(OFS_TX_DATA_BIT_MASK, MASK_RESET, RESP_OKAY);
        wr(OFS_SHARED_GLOBAL_CTRL, 32'h0000_001f, RESP_OKAY);
        wr(ALS, 32'hffff_ffff, RESP_OKAY);
        check("run levels", {22'h0, runs}, 32'h0000_03ff);
        rd(ALS, 32'h0000_1f1f, RESP_OKAY);
        rd(OFS_SHARED_GLOBAL_CTRL, 32'h0000_1f1f, RESP_OKAY);
        wr(ALS, 32'h0000_00e0, RESP_OKAY);
        check("rx kept", {22'h0, runs}, 32'h0000_001f);
        for (n = 0; n < 5; n++)
        begin
            wr(ALS, 32'h0000_0100 << n, RESP_OKAY);
            check("tx run", {22'h0, runs}, (32'h20 << n) | 32'h1f);
        end
        wr(8'h10, 32'hffff_ffff, RESP_SLVERR);
        rd(8'h10, 32'h0000_0000, RESP_SLVERR);
        wr(OFS_TX_DATA_BIT_MASK, M0, RESP_OKAY);
        rd(OFS_TX_DATA_BIT_MASK, M0, RESP_OKAY);
        wr(ALS, 32'h0000_1c00, RESP_OKAY);
        for (n = 0; n < 5; n++)
        begin
            sel = (n == 4) ? PAD_SEL_DATA_BIT : n[1:0];
            src = (n == 4) ? 5'h1f : 5'h04;
            wr(OFS_TX_PAD_CTRL, {19'h0, src, 6'h0, sel}, RESP_OKAY);
            push(W0, ok);
            pad = (sel == 1 || (sel == 2 && W0[src])) ? '1 : '0;
            wait_out(n + 1);
            check("masked word", u_sink.seen[n], (W0 & M0) | (pad & ~M0));
        end
        wr(ALS, 32'h0000_1400, RESP_OKAY);
        push(W0, ok);
        repeat (10) @(posedge aclk);
        check("held words", u_sink.seen.size(), 5);
        wr(ALS, 32'h0000_1c00, RESP_OKAY);
        wait_out(6);
        check("released word", u_sink.seen[5], W0 & M0);
        wr(OFS_TX_DATA_BIT_MASK, 32'hffff_ffff, RESP_OKAY);
        @(posedge aclk);
        stall <= 1'b1;
        n = 0;
        ok = 1'b1;
        while (ok && n < 8)
        begin
            push(32'h0000_00a0 + n, ok);
            if (ok) n++;
        end
        check("words taken", n, DEPTH + 1);
        @(posedge aclk);
        slow <= 1'b1;
        stall <= 1'b0;
        wait_out(11);
        for (n = 0; n < 5; n++)
            check("drained word", u_sink.seen[6 + n], 32'h0000_00a0 + n);
        wr(ALS, 32'h0000_1800, RESP_OKAY);
        push(W0, ok);
        check("taken while cleared", {31'h0, ok}, 32'h0);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(OFS_TX_DATA_BIT_MASK, MASK_RESET, RESP_OKAY);
        rd(ALS, 32'h0000_0000, RESP_OKAY);
        finish_test();
    end
endmodule
`default_nettype wire

// *** atram_pkg.sv ***
package atram_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int BYTE_W = 8;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0] OFS_SHARED_GLOBAL_CTRL = 8'h44;
    localparam logic [7:0] OFS_TX_GLOBAL_CTRL_ALIAS = 8'ha0;
    localparam logic [7:0] OFS_TX_DATA_BIT_MASK = 8'ha4;
    localparam logic [7:0] OFS_TX_PAD_CTRL = 8'hb0;

    // ****************************************
    // shared global control word layout
    // ****************************************
    localparam int GBL_W = 13;
    localparam int BIT_TX_FSYNC_GEN_RUN = 12;
    localparam int BIT_TX_STATE_MACHINE_RUN = 11;
    localparam int BIT_TX_SERIALIZER_ACTIVE = 10;
    localparam int BIT_TX_HF_DIVIDER_RUN = 9;
    localparam int BIT_TX_BIT_DIVIDER_RUN = 8;
    localparam int BIT_RX_FSYNC_GEN_RUN = 4;
    localparam int BIT_RX_STATE_MACHINE_RUN = 3;
    localparam int BIT_RX_SERIALIZER_ACTIVE = 2;
    localparam int BIT_RX_HF_DIVIDER_RUN = 1;
    localparam int BIT_RX_BIT_DIVIDER_RUN = 0;
    localparam logic [12:0] GBL_TX_BITS = 13'h1f00;
    localparam logic [12:0] GBL_RX_BITS = 13'h001f;
    localparam logic [12:0] GBL_RESET = 13'h0000;

    // ****************************************
    // mask and pad control
    // ****************************************
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam int PAD_SEL_LSB = 0;
    localparam int PAD_SEL_W = 2;
    localparam int PAD_BIT_LSB = 8;
    localparam int PAD_BIT_W = 5;
    localparam logic [1:0] PAD_SEL_ZERO = 2'h0;
    localparam logic [1:0] PAD_SEL_ONE = 2'h1;
    localparam logic [1:0] PAD_SEL_DATA_BIT = 2'h2;
    localparam logic [1:0] PAD_SEL_RESET = 2'h0;
    localparam logic [4:0] PAD_BIT_RESET = 5'h00;

    // ****************************************
    // bus answers
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** atram_sink.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// downstream word sink
// ****
module atram_sink
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pacing
    input wire logic stall,
    input wire logic slow,
    // masked words
    input wire logic tx_out_valid,
    input wire logic [31:0] tx_out_data,
    output logic tx_out_ready
);
    logic [31:0] seen [$];
    logic phase_r;
    always_ff @(posedge aclk)
    begin
        phase_r <= aresetn && !phase_r;
        if (aresetn && tx_out_valid && tx_out_ready)
            seen.push_back(tx_out_data);
    end
    // slow mode accepts every other cycle to exercise back pressure
    assign tx_out_ready = aresetn && !stall && (!slow || phase_r);
endmodule
`default_nettype wire

// *** atram_top.sv ***
// Functional notes
// - alias write touches only transmit bits 12-8
// - alias read returns whole global word
// - transmitter reset without disturbing receiver bits
// - bit 12 runs transmit frame-sync generator
// - bit 11 releases transmit state machine
// - bit 10 activates transmit serializers
// - bit 9 runs high-frequency clock divider
// - bit 8 runs bit clock divider
// - alias bits 4-0 mirror receive, ignore writes
// - reserved alias bits read zero, unwritable
// - mask bit 0 pads, 1 passes data
// - masking precedes reversal and rotation
// - alias and mask reset to zero
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// transmit word fifo
// ****************************************
module atram_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // flush
    input wire logic clear,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PTR_W = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
        begin : g_bad
            $error("atram_fifo: depth must be a power of two >= 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [PTR_W:0] count;
        logic not_full;
    } atram_fifo_state_type;

    atram_fifo_state_type st_r;
    atram_fifo_state_type st_nxt;
    logic push;
    logic pop;

    assign out_valid = (st_r.count != '0);
    assign out_data = st_r.mem[st_r.rd_ptr];
    // ready is a flop so the source sees a clean level
    assign in_ready = st_r.not_full;
    assign push = in_valid && st_r.not_full && !clear;
    assign pop = out_valid && out_ready && !clear;

    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wr_ptr] = in_data;
            st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
        end
        st_nxt.count = st_r.count + {{PTR_W{1'b0}}, push}
            - {{PTR_W{1'b0}}, pop};
        if (clear)
        begin
            st_nxt.wr_ptr = '0;
            st_nxt.rd_ptr = '0;
            st_nxt.count = '0;
        end
        st_nxt.not_full = (st_nxt.count != DEPTH[PTR_W:0]);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            st_r.not_full <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
endmodule

// ****************************************
// control alias, mask unit and register slave
// ****************************************
module atram_top
    import atram_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    output logic awready,
    // axi4-lite write data
    input wire logic wvalid,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [STRB_W-1:0] wstrb,
    output logic wready,
    // axi4-lite write response
    output logic bvalid,
    output logic [1:0] bresp,
    input wire logic bready,
    // axi4-lite read address
    input wire logic arvalid,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic arready,
    // axi4-lite read data
    output logic rvalid,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    input wire logic rready,
    // transmit words in
    input wire logic tx_in_valid,
    input wire logic [DATA_W-1:0] tx_in_data,
    output logic tx_in_ready,
    // masked words out, toward reversal and rotation
    output logic tx_out_valid,
    output logic [DATA_W-1:0] tx_out_data,
    input wire logic tx_out_ready,
    // transmit section run levels
    output logic tx_fsync_gen_run,
    output logic tx_state_machine_run,
    output logic tx_serializer_active,
    output logic tx_hf_divider_run,
    output logic tx_bit_divider_run,
    // receive section run levels
    output logic rx_fsync_gen_run,
    output logic rx_state_machine_run,
    output logic rx_serializer_active,
    output logic rx_hf_divider_run,
    output logic rx_bit_divider_run
);
    generate
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
        begin : g_bad
            $error("atram_top: fifo depth must be a power of two >= 2");
        end
    endgenerate

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [DATA_W-1:0] w_data;
        logic [STRB_W-1:0] w_strb;
        logic [GBL_W-1:0] gbl;
        logic [DATA_W-1:0] mask;
        logic [PAD_SEL_W-1:0] pad_sel;
        logic [PAD_BIT_W-1:0] pad_bit;
        logic out_valid;
        logic [DATA_W-1:0] out_data;
        logic fifo_ready;
    } atram_state_type;

    atram_state_type st_r;
    atram_state_type st_nxt;
    logic fifo_in_ready;
    logic fifo_push;
    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic fifo_pop;
    logic fifo_clear;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a == OFS_SHARED_GLOBAL_CTRL)
            || (a == OFS_TX_GLOBAL_CTRL_ALIAS)
            || (a == OFS_TX_DATA_BIT_MASK)
            || (a == OFS_TX_PAD_CTRL);
    endfunction

    function automatic logic [DATA_W-1:0] reg_read(
        input logic [ADDR_W-1:0] a,
        input atram_state_type s
    );
        reg_read = '0;
        case (a)
            // full word incl. receive bits; reserved bits zero
            OFS_SHARED_GLOBAL_CTRL,
            OFS_TX_GLOBAL_CTRL_ALIAS:
                reg_read = {{(DATA_W-GBL_W){1'b0}}, s.gbl};
            OFS_TX_DATA_BIT_MASK:
                reg_read = s.mask;
            OFS_TX_PAD_CTRL:
            begin
                reg_read[PAD_SEL_LSB +: PAD_SEL_W] = s.pad_sel;
                reg_read[PAD_BIT_LSB +: PAD_BIT_W] = s.pad_bit;
            end
            default:
                reg_read = '0;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] strb_merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [STRB_W-1:0] strb
    );
        strb_merge = old_v;
        for (int i = 0; i < STRB_W; i++)
        begin
            if (strb[i])
            begin
                strb_merge[i*BYTE_W +: BYTE_W] = new_v[i*BYTE_W +: BYTE_W];
            end
        end
    endfunction

    function automatic logic [DATA_W-1:0] apply_mask(
        input logic [DATA_W-1:0] d,
        input logic [DATA_W-1:0] m,
        input logic [PAD_SEL_W-1:0] sel,
        input logic [PAD_BIT_W-1:0] src
    );
        logic [DATA_W-1:0] pad;
        pad = '0;
        case (sel)
            PAD_SEL_ONE:
                pad = '1;
            PAD_SEL_DATA_BIT:
                pad = {DATA_W{d[src]}};
            default:
                pad = '0;
        endcase
        apply_mask = (d & m) | (pad & ~m);
    endfunction

    // ****************************************
    // fifo ahead of the mask unit
    // ****************************************
    atram_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(fifo_clear),
        .in_valid(fifo_push),
        .in_data(tx_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_pop)
    );

    // only words the source saw accepted enter the fifo
    assign fifo_push = tx_in_valid && st_r.fifo_ready;
    // cleared serializers drop queued words
    assign fifo_clear = !st_r.gbl[BIT_TX_SERIALIZER_ACTIVE];
    // state machine in reset stops the flow without losing words
    assign fifo_pop = st_r.gbl[BIT_TX_STATE_MACHINE_RUN]
        && (!st_r.out_valid || tx_out_ready);

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [DATA_W-1:0] merged;
        logic [ADDR_W-1:0] wa;
        merged = '0;
        wa = '0;
        st_nxt = st_r;

        // write channel capture, either order
        if (awvalid && st_r.awready)
        begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = awaddr;
        end
        if (wvalid && st_r.wready)
        begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = wdata;
            st_nxt.w_strb = wstrb;
        end
        if (bvalid && bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        if (st_nxt.aw_have && st_nxt.w_have && !st_nxt.bvalid)
        begin
            wa = st_nxt.aw_addr;
            merged = strb_merge(reg_read(wa, st_r), st_nxt.w_data,
                st_nxt.w_strb);
            case (wa)
                // one store behind both addresses
                OFS_SHARED_GLOBAL_CTRL:
                    st_nxt.gbl = merged[GBL_W-1:0]
                        & (GBL_TX_BITS | GBL_RX_BITS);
                // receive and reserved bits kept as they were
                OFS_TX_GLOBAL_CTRL_ALIAS:
                    st_nxt.gbl = (st_r.gbl & ~GBL_TX_BITS)
                        | (merged[GBL_W-1:0] & GBL_TX_BITS);
                OFS_TX_DATA_BIT_MASK:
                    st_nxt.mask = merged;
                OFS_TX_PAD_CTRL:
                begin
                    st_nxt.pad_sel = merged[PAD_SEL_LSB +: PAD_SEL_W];
                    st_nxt.pad_bit = merged[PAD_BIT_LSB +: PAD_BIT_W];
                end
                default:
                    st_nxt.gbl = st_r.gbl;
            endcase
            st_nxt.bresp = addr_hit(wa) ? RESP_OKAY : RESP_SLVERR;
            st_nxt.bvalid = 1'b1;
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
        end
        st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;

        // read channel, one outstanding
        if (rvalid && rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        if (arvalid && st_r.arready)
        begin
            st_nxt.rdata = reg_read(araddr, st_r);
            st_nxt.rresp = addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
            st_nxt.rvalid = 1'b1;
        end
        st_nxt.arready = !st_nxt.rvalid;

        // mask stage, ahead of reversal and rotation
        if (st_r.out_valid && tx_out_ready)
        begin
            st_nxt.out_valid = 1'b0;
        end
        if (fifo_pop && fifo_out_valid)
        begin
            st_nxt.out_valid = 1'b1;
            st_nxt.out_data = apply_mask(fifo_out_data, st_r.mask,
                st_r.pad_sel, st_r.pad_bit);
        end
        if (!st_r.gbl[BIT_TX_SERIALIZER_ACTIVE])
        begin
            st_nxt.out_valid = 1'b0;
            st_nxt.out_data = '0;
        end
        // ready drops after each push: a full fifo is never offered
        st_nxt.fifo_ready = fifo_in_ready && !fifo_clear && !fifo_push;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            st_r.gbl <= GBL_RESET;
            st_r.mask <= MASK_RESET;
            st_r.pad_sel <= PAD_SEL_RESET;
            st_r.pad_bit <= PAD_BIT_RESET;
            st_r.bresp <= RESP_OKAY;
            st_r.rresp <= RESP_OKAY;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign awready = st_r.awready;
    assign wready = st_r.wready;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = st_r.arready;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    // two cycles late after a fifo pop: safe, never over-accepts
    assign tx_in_ready = st_r.fifo_ready;
    assign tx_out_valid = st_r.out_valid;
    assign tx_out_data = st_r.out_data;
    assign tx_fsync_gen_run = st_r.gbl[BIT_TX_FSYNC_GEN_RUN];
    assign tx_state_machine_run = st_r.gbl[BIT_TX_STATE_MACHINE_RUN];
    assign tx_serializer_active = st_r.gbl[BIT_TX_SERIALIZER_ACTIVE];
    assign tx_hf_divider_run = st_r.gbl[BIT_TX_HF_DIVIDER_RUN];
    assign tx_bit_divider_run = st_r.gbl[BIT_TX_BIT_DIVIDER_RUN];
    assign rx_fsync_gen_run = st_r.gbl[BIT_RX_FSYNC_GEN_RUN];
    assign rx_state_machine_run = st_r.gbl[BIT_RX_STATE_MACHINE_RUN];
    assign rx_serializer_active = st_r.gbl[BIT_RX_SERIALIZER_ACTIVE];
    assign rx_hf_divider_run = st_r.gbl[BIT_RX_HF_DIVIDER_RUN];
    assign rx_bit_divider_run = st_r.gbl[BIT_RX_BIT_DIVIDER_RUN];
endmodule

`default_nettype wire

// *** atram_top_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****
// register bus and control checks
// ****
module atram_checker
    import atram_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic awvalid,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [DATA_W-1:0] rdata,
    // stream
    input wire logic tx_in_ready,
    input wire logic tx_out_valid,
    input wire logic [DATA_W-1:0] tx_out_data,
    input wire logic tx_out_ready,
    // run levels
    input wire logic tx_fsync_gen_run,
    input wire logic tx_state_machine_run,
    input wire logic tx_serializer_active,
    input wire logic tx_hf_divider_run,
    input wire logic tx_bit_divider_run,
    input wire logic rx_fsync_gen_run,
    input wire logic rx_state_machine_run,
    input wire logic rx_serializer_active,
    input wire logic rx_hf_divider_run,
    input wire logic rx_bit_divider_run
);
    wire logic [4:0] tx_v = {tx_fsync_gen_run, tx_state_machine_run,
        tx_serializer_active, tx_hf_divider_run, tx_bit_divider_run};
    wire logic [4:0] rx_v = {rx_fsync_gen_run, rx_state_machine_run,
        rx_serializer_active, rx_hf_divider_run, rx_bit_divider_run};
    // only the paired beat form is watched; split beats go unchecked
    wire logic alias_wr = awvalid && awready && wvalid && wready &&
        awaddr == OFS_TX_GLOBAL_CTRL_ALIAS;
    logic ar_alias_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ar_alias_r <= 1'b0;
        else if (arvalid && arready)
            ar_alias_r <= araddr == OFS_TX_GLOBAL_CTRL_ALIAS;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_zero_a: assert property ($rose(aresetn) |-> !{tx_v, rx_v})
        else $error("run levels not clear after reset");
    rx_keep_a: assert property (alias_wr |=> $stable(rx_v) [*2])
        else $error("alias write moved receive levels");
    alias_read_a: assert property ($rose(rvalid) && ar_alias_r &&
        $stable({tx_v, rx_v}) |-> rdata == {19'h0, tx_v, 3'h0, rx_v})
        else $error("alias read differs from global word");
    in_ready_a: assert property (!tx_serializer_active |=> !tx_in_ready)
        else $error("words taken while serializers cleared");
    sm_stall_a: assert property ($rose(tx_out_valid) |->
        $past(tx_state_machine_run))
        else $error("word sent while state machine held");
    out_hold_a: assert property (tx_out_valid && !tx_out_ready &&
        tx_serializer_active |=> !tx_serializer_active ||
        (tx_out_valid && $stable(tx_out_data)))
        else $error("stalled word changed");
    wr_answer_a: assert property (awvalid && awready && wvalid && wready
        |=> bvalid)
        else $error("write answer late");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    rd_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    ar_block_a: assert property (rvalid |-> !arready)
        else $error("read taken while answer pending");
    cover property (alias_wr);
    cover property ($rose(rvalid) && ar_alias_r);
    cover property (tx_out_valid && tx_out_ready);
endmodule
bind atram_top atram_checker u_chk (.aclk, .aresetn, .awvalid, .awaddr,
    .awready, .wvalid, .wready, .bvalid, .bresp, .bready, .arvalid,
    .araddr, .arready, .rvalid, .rdata, .tx_in_ready, .tx_out_valid,
    .tx_out_data, .tx_out_ready, .tx_fsync_gen_run, .tx_state_machine_run,
    .tx_serializer_active, .tx_hf_divider_run, .tx_bit_divider_run,
    .rx_fsync_gen_run, .rx_state_machine_run, .rx_serializer_active,
    .rx_hf_divider_run, .rx_bit_divider_run);
`default_nettype wire
